/* design/host_csr.sv */
`timescale 1ns/1ps
`default_nettype none
`include "host_csr_regs.svh"

// ------------------------------------------------------------
// sixteen-entry queue with a soft capacity limit
// ------------------------------------------------------------
module word_queue (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire logic [31:0] din,
  input wire logic pop,
  input wire logic [4:0] lim,
  output logic [31:0] head,
  output logic not_full_q,
  output logic not_empty_q,
  output logic [4:0] count_q
);
  logic [31:0] mem [16];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic do_push;
  logic do_pop;
  logic [4:0] count_d;

  // push refused when full, pop refused when empty
  assign do_push = push && not_full_q;
  assign do_pop = pop && not_empty_q;
  assign head = mem[rd_ptr_q];
  assign count_d = count_q + {4'h0, do_push} - {4'h0, do_pop};

  // storage has no reset: only pointers, count and flags are reset
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= din;
    end
  end

  // pointers, fill count and registered flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
      not_full_q <= 1'b1;
      not_empty_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + {3'h0, do_push};
      rd_ptr_q <= rd_ptr_q + {3'h0, do_pop};
      count_q <= count_d;
      not_full_q <= count_d < lim;
      not_empty_q <= count_d != 5'h00;
    end
  end
endmodule : word_queue

module host_csr
  import host_csr_pkg::*;
#(
  parameter half_t CHIP_CODE = 16'h0a5c, // arbitrary value
  parameter half_t CHIP_REV = 16'h0001 // arbitrary value
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  input wire logic rx_status_push,
  input wire logic [31:0] rx_status_word,
  output logic rx_status_ready,
  input wire logic rx_data_push,
  input wire logic [31:0] rx_data_word,
  output logic rx_data_ready,
  input wire logic tx_status_push,
  input wire logic [31:0] tx_status_word,
  output logic tx_status_ready,
  output logic tx_data_avail,
  input wire logic tx_data_take,
  output logic [31:0] tx_data_out,
  output logic tx_data_strobe,
  input wire logic rx_drop_event,
  output logic mac_req,
  output logic mac_write,
  output logic [7:0] mac_index,
  output logic [31:0] mac_wdata,
  input wire logic mac_ack,
  input wire logic [31:0] mac_rdata
);
  localparam word_t BYTE_ORDER = `BYTE_ORDER_VALUE;
  localparam int TICK_LAST = `TICK_CYCLES - 1;

  logic rst;
  logic soft_rst_q;
  logic [7:0] waddr;
  logic hi_half, rd_lo, rd_hi, wr_commit, is_data_port;
  word_t wword, rd_mux, rd_word_q;
  half_t wr_lo_q, host_rdata_q;
  logic host_rvalid_q;
  word_t irq_cfg_q, irq_sts_q, irq_en_q, ql_irq_q, rx_cfg_q, tx_cfg_q;
  word_t hardware_config_q, rx_path_q, pm_ctl_q, gpio_q, tmr_cfg_q, swap_q;
  word_t afc_q, rom_cmd_q, rom_data_q, tmr_cnt_q, free_q, drop_q;
  word_t mac_cmd_q, mac_data_q, tx_out_q;
  logic [4:0] tick_q;
  logic tick;
  mac_state_e mac_st_q;
  logic mac_req_q, mac_write_q, tx_strobe_q;
  logic [7:0] mac_index_q;
  word_t mac_wdata_q;
  word_t rxs_head, rxd_head, txs_head, txd_head;
  logic rxs_ne, rxd_ne, txs_ne, txd_ne;
  qcount_t rxs_cnt, rxd_cnt, txs_cnt, txd_cnt, tx_lim, rx_lim;
  logic rxs_pop, rxd_pop, txs_pop, txd_push, drop_clr;
  half_t tx_free;

  // ----------------------------------------------------------
  // reset and half-word pairing
  // ----------------------------------------------------------
  // software reset is a one-cycle pulse folded into the system reset
  assign rst = !resetn || soft_rst_q;
  assign hi_half = host_addr[1];
  assign waddr = {host_addr[7:2], 2'b00};
  assign rd_lo = host_rd && !hi_half;
  assign rd_hi = host_rd && hi_half; // side effects fire on second half
  assign wr_commit = host_wr && hi_half;
  assign wword = {host_wdata, wr_lo_q};
  assign is_data_port = waddr[7:6] == 2'b00;

  // only resetn clears this, else the pulse would cut itself short
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_commit && waddr == `OFF_HARDWARE_CONFIG &&
                    wword[`BIT_SOFT_RESET];
    end
  end

  // low half of a write waits here until the high half commits
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_lo_q <= 16'h0000;
    end else if (host_wr && !hi_half) begin
      wr_lo_q <= host_wdata;
    end
  end

  // ----------------------------------------------------------
  // queues
  // ----------------------------------------------------------
  // transmit share set by config; zero means the full sixteen
  assign tx_lim = (hardware_config_q[`FLD_TXQ_LIMIT_HI:`FLD_TXQ_LIMIT_LO] == 4'h0) ?
                  5'h10 : {1'b0, hardware_config_q[`FLD_TXQ_LIMIT_HI:`FLD_TXQ_LIMIT_LO]};
  assign rx_lim = 5'h11 - tx_lim;
  assign rxs_pop = rd_hi && waddr == `OFF_RX_STATUS_POP;
  assign rxd_pop = rd_hi && is_data_port;
  assign txs_pop = rd_hi && waddr == `OFF_TX_STATUS_POP;
  assign txd_push = wr_commit && is_data_port;

  // no host write path reaches the receive queues
  word_queue u_rx_status (.mclk(mclk), .rst(rst), .push(rx_status_push),
    .din(rx_status_word), .pop(rxs_pop), .lim(rx_lim), .head(rxs_head),
    .not_full_q(rx_status_ready), .not_empty_q(rxs_ne), .count_q(rxs_cnt));
  word_queue u_rx_data (.mclk(mclk), .rst(rst), .push(rx_data_push),
    .din(rx_data_word), .pop(rxd_pop), .lim(rx_lim), .head(rxd_head),
    .not_full_q(rx_data_ready), .not_empty_q(rxd_ne), .count_q(rxd_cnt));
  word_queue u_tx_status (.mclk(mclk), .rst(rst), .push(tx_status_push),
    .din(tx_status_word), .pop(txs_pop), .lim(5'h10), .head(txs_head),
    .not_full_q(tx_status_ready), .not_empty_q(txs_ne), .count_q(txs_cnt));
  word_queue u_tx_data (.mclk(mclk), .rst(rst), .push(txd_push),
    .din(wword), .pop(tx_data_take), .lim(tx_lim), .head(txd_head),
    .not_full_q(), .not_empty_q(txd_ne), .count_q(txd_cnt));
  assign tx_data_avail = txd_ne;

  // word handed to the core one cycle after it takes
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_out_q <= `RST_ZERO;
      tx_strobe_q <= 1'b0;
    end else begin
      tx_strobe_q <= tx_data_take && txd_ne;
      if (tx_data_take && txd_ne) begin
        tx_out_q <= txd_head;
      end
    end
  end

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------
  assign tx_free = `RST_TX_QUEUE_FREE - {9'h000, txd_cnt, 2'b00};

  // empty queues read as zero rather than stale memory
  always_comb begin
    rd_mux = `RST_ZERO;
    if (is_data_port) begin
      rd_mux = rxd_ne ? rxd_head : `RST_ZERO;
    end else begin
      case (waddr)
        `OFF_RX_STATUS_POP, `OFF_RX_STATUS_PEEK: begin
          rd_mux = rxs_ne ? rxs_head : `RST_ZERO;
        end
        `OFF_TX_STATUS_POP, `OFF_TX_STATUS_PEEK: begin
          rd_mux = txs_ne ? txs_head : `RST_ZERO;
        end
        `OFF_CHIP_IDENTITY: rd_mux = {CHIP_CODE, CHIP_REV};
        `OFF_INTERRUPT_CONFIG: rd_mux = irq_cfg_q;
        `OFF_INTERRUPT_STATUS: rd_mux = irq_sts_q;
        `OFF_INTERRUPT_ENABLE: rd_mux = irq_en_q;
        `OFF_BYTE_ORDER_PROBE: rd_mux = BYTE_ORDER;
        `OFF_QUEUE_LEVEL_IRQ: rd_mux = ql_irq_q;
        `OFF_RECEIVE_CONFIG: rd_mux = rx_cfg_q;
        `OFF_TRANSMIT_CONFIG: rd_mux = tx_cfg_q;
        `OFF_HARDWARE_CONFIG: rd_mux = hardware_config_q;
        `OFF_RECEIVE_PATH_CONTROL: rd_mux = rx_path_q;
        `OFF_RECEIVE_QUEUE_INFO: rd_mux = {11'h000, rxs_cnt, 11'h000, rxd_cnt};
        `OFF_TRANSMIT_QUEUE_INFO: rd_mux = {11'h000, txs_cnt, tx_free};
        `OFF_POWER_MGMT_CONTROL: rd_mux = pm_ctl_q;
        `OFF_GENERAL_IO_CONFIG: rd_mux = gpio_q;
        `OFF_TIMER_CONFIG: rd_mux = tmr_cfg_q;
        `OFF_TIMER_COUNT: rd_mux = tmr_cnt_q;
        `OFF_HALFWORD_SWAP: rd_mux = swap_q;
        `OFF_FREE_RUNNING_COUNTER: rd_mux = free_q;
        `OFF_DROPPED_FRAME_COUNTER: rd_mux = drop_q;
        `OFF_MAC_INDIRECT_COMMAND: rd_mux = mac_cmd_q;
        `OFF_MAC_INDIRECT_DATA: rd_mux = mac_data_q;
        `OFF_AUTO_FLOW_CONTROL_CONFIG: rd_mux = afc_q;
        `OFF_SERIAL_ROM_COMMAND: rd_mux = rom_cmd_q;
        `OFF_SERIAL_ROM_DATA: rd_mux = rom_data_q;
        default: rd_mux = `RST_ZERO;
      endcase
    end
  end

  // low half snapshots the whole word so both halves are coherent
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_word_q <= `RST_ZERO;
      host_rdata_q <= 16'h0000;
      host_rvalid_q <= 1'b0;
    end else begin
      host_rvalid_q <= host_rd;
      if (rd_lo) begin
        rd_word_q <= rd_mux;
        host_rdata_q <= rd_mux[15:0];
      end else if (rd_hi) begin
        host_rdata_q <= rd_word_q[31:16];
      end
    end
  end
  assign host_rdata = host_rdata_q;
  assign host_rvalid = host_rvalid_q;

  // ----------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------
  // unlisted offsets fall through: reserved writes vanish
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_cfg_q <= `RST_ZERO;
      irq_en_q <= `RST_ZERO;
      ql_irq_q <= `RST_QUEUE_LEVEL_IRQ;
      rx_cfg_q <= `RST_ZERO;
      tx_cfg_q <= `RST_ZERO;
      hardware_config_q <= `RST_HARDWARE_CONFIG;
      rx_path_q <= `RST_ZERO;
      pm_ctl_q <= `RST_ZERO;
      gpio_q <= `RST_ZERO;
      tmr_cfg_q <= `RST_TIMER_CONFIG;
      swap_q <= `RST_ZERO;
      afc_q <= `RST_ZERO;
      rom_cmd_q <= `RST_ZERO;
      rom_data_q <= `RST_ZERO;
    end else if (wr_commit) begin
      case (waddr)
        `OFF_INTERRUPT_CONFIG: irq_cfg_q <= wword;
        `OFF_INTERRUPT_ENABLE: irq_en_q <= wword;
        `OFF_QUEUE_LEVEL_IRQ: ql_irq_q <= wword;
        `OFF_RECEIVE_CONFIG: rx_cfg_q <= wword;
        `OFF_TRANSMIT_CONFIG: tx_cfg_q <= wword;
        `OFF_HARDWARE_CONFIG: hardware_config_q <= {wword[31:1], 1'b0};
        `OFF_RECEIVE_PATH_CONTROL: rx_path_q <= wword;
        `OFF_POWER_MGMT_CONTROL: pm_ctl_q <= wword;
        `OFF_GENERAL_IO_CONFIG: gpio_q <= wword;
        `OFF_TIMER_CONFIG: tmr_cfg_q <= wword;
        `OFF_HALFWORD_SWAP: swap_q <= wword;
        `OFF_AUTO_FLOW_CONTROL_CONFIG: afc_q <= wword;
        `OFF_SERIAL_ROM_COMMAND: rom_cmd_q <= wword;
        `OFF_SERIAL_ROM_DATA: rom_data_q <= wword;
        default: ;
      endcase
    end
  end

  // software interrupt: enable bit sets it, write-one clears; set wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_sts_q <= `RST_ZERO;
    end else if (irq_en_q[`BIT_SOFT_IRQ]) begin
      irq_sts_q <= irq_sts_q | (32'h1 << `BIT_SOFT_IRQ);
    end else if (wr_commit && waddr == `OFF_INTERRUPT_STATUS) begin
      irq_sts_q <= irq_sts_q & ~wword;
    end
  end

  // ----------------------------------------------------------
  // counters and timer
  // ----------------------------------------------------------
  // microsecond enable keeps the timer on the single clock
  assign tick = tick_q == TICK_LAST[4:0];
  assign drop_clr = rd_hi && waddr == `OFF_DROPPED_FRAME_COUNTER;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_q <= 5'h00;
      free_q <= `RST_ZERO;
    end else begin
      tick_q <= tick ? 5'h00 : tick_q + 5'h01;
      free_q <= free_q + 32'h1;
    end
  end

  // writing the config reloads the count at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      tmr_cnt_q <= `RST_TIMER_COUNT;
    end else if (wr_commit && waddr == `OFF_TIMER_CONFIG) begin
      tmr_cnt_q <= {16'h0000, wword[15:0]};
    end else if (tick && tmr_cfg_q[`BIT_TIMER_ENABLE]) begin
      tmr_cnt_q <= (tmr_cnt_q == `RST_ZERO) ? {16'h0000, tmr_cfg_q[15:0]} :
                   tmr_cnt_q - 32'h1;
    end
  end

  // clear on read; a drop in the same cycle survives as one
  always_ff @(posedge mclk) begin
    if (rst) begin
      drop_q <= `RST_ZERO;
    end else if (rx_drop_event) begin
      drop_q <= drop_clr ? 32'h1 : drop_q + 32'h1;
    end else if (drop_clr) begin
      drop_q <= `RST_ZERO;
    end
  end

  // ----------------------------------------------------------
  // indirect mac access
  // ----------------------------------------------------------
  // busy bit holds while the mac side is working; commands written meanwhile are dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      mac_st_q <= MAC_IDLE;
      mac_cmd_q <= `RST_ZERO;
      mac_data_q <= `RST_ZERO;
      mac_req_q <= 1'b0;
      mac_write_q <= 1'b0;
      mac_index_q <= 8'h00;
      mac_wdata_q <= `RST_ZERO;
    end else begin
      mac_req_q <= 1'b0;
      case (mac_st_q)
        MAC_IDLE: begin
          if (wr_commit && waddr == `OFF_MAC_INDIRECT_DATA) begin
            mac_data_q <= wword;
          end
          if (wr_commit && waddr == `OFF_MAC_INDIRECT_COMMAND) begin
            mac_cmd_q <= wword;
            if (wword[`BIT_MAC_BUSY]) begin
              mac_req_q <= 1'b1;
              mac_write_q <= !wword[`BIT_MAC_READ];
              mac_index_q <= wword[7:0];
              mac_wdata_q <= mac_data_q;
              mac_st_q <= MAC_WAIT;
            end
          end
        end
        MAC_WAIT: begin
          if (mac_ack) begin
            mac_cmd_q[`BIT_MAC_BUSY] <= 1'b0;
            if (!mac_write_q) begin
              mac_data_q <= mac_rdata;
            end
            mac_st_q <= MAC_IDLE;
          end
        end
        default: mac_st_q <= MAC_IDLE;
      endcase
    end
  end
  assign mac_req = mac_req_q;
  assign mac_write = mac_write_q;
  assign mac_index = mac_index_q;
  assign mac_wdata = mac_wdata_q;
  assign tx_data_out = tx_out_q;
  assign tx_data_strobe = tx_strobe_q;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_pair(logic [7:0] a);
    rd_lo && waddr == a ##1 host_rd && hi_half;
  endsequence
  sequence s_mac_start;
    wr_commit && waddr == `OFF_MAC_INDIRECT_COMMAND &&
      wword[`BIT_MAC_BUSY] && mac_st_q == MAC_IDLE;
  endsequence

  a_status_pop_removes: assert property (
    rxs_pop && rxs_ne && !rx_status_push |=>
      rxs_cnt + 5'h01 == $past(rxs_cnt)) else $error("status pop lost");
  a_status_peek_keeps: assert property (
    rd_hi && waddr == `OFF_RX_STATUS_PEEK && !rx_status_push |=>
      $stable(rxs_cnt)) else $error("status peek popped");
  a_alias_read_pops: assert property (
    rd_hi && is_data_port && rxd_ne && !rx_data_push |=>
      rxd_cnt + 5'h01 == $past(rxd_cnt)) else $error("alias read no pop");
  a_rx_write_ignored: assert property (
    host_wr && !host_rd && !rx_data_push && !rx_status_push |=>
      $stable(rxd_cnt) && $stable(rxs_cnt)) else $error("rx queue written");
  a_tx_peek_keeps: assert property (
    rd_hi && waddr == `OFF_TX_STATUS_PEEK && !tx_status_push |=>
      $stable(txs_cnt)) else $error("tx peek popped");
  a_tx_pop_removes: assert property (
    txs_pop && txs_ne && !tx_status_push |=>
      txs_cnt + 5'h01 == $past(txs_cnt)) else $error("tx pop lost");
  a_tx_alias_push: assert property (
    txd_push && txd_cnt < tx_lim && !tx_data_take |=>
      txd_cnt == $past(txd_cnt) + 5'h01) else $error("tx push lost");
  a_probe_reads_const: assert property (
    s_pair(`OFF_BYTE_ORDER_PROBE) |=> host_rvalid &&
      host_rdata == BYTE_ORDER[31:16]) else $error("probe high half");
  a_identity_pair: assert property (
    s_pair(`OFF_CHIP_IDENTITY) |=> host_rdata == CHIP_CODE)
    else $error("identity high half");
  a_reserved_zero: assert property (
    rd_lo && (waddr == `OFF_RESERVED_A || waddr == `OFF_RESERVED_B ||
      waddr >= 8'hb8) |=> host_rdata == 16'h0000) else $error("reserved");
  a_reset_defaults: assert property (
    $past(rst) |-> ql_irq_q == `RST_QUEUE_LEVEL_IRQ &&
      hardware_config_q == `RST_HARDWARE_CONFIG && tmr_cnt_q == `RST_TIMER_COUNT)
    else $error("reset default wrong");
  a_mac_request: assert property (
    s_mac_start |=> mac_req_q ##1 !mac_req_q) else $error("mac request");
endmodule : host_csr
`default_nettype wire

/* design/host_csr_pkg.sv */
package host_csr_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] half_t;
  typedef logic [4:0] qcount_t;
  typedef enum logic {MAC_IDLE, MAC_WAIT} mac_state_e;
endpackage : host_csr_pkg

/* design/host_csr_regs.svh */
`ifndef HOST_CSR_REGS_SVH
`define HOST_CSR_REGS_SVH
// ------------------------------------------------------------
// offsets (byte addresses, one aligned doubleword each)
// ------------------------------------------------------------
`define OFF_RX_STATUS_POP 8'h40
`define OFF_RX_STATUS_PEEK 8'h44
`define OFF_TX_STATUS_POP 8'h48
`define OFF_TX_STATUS_PEEK 8'h4c
`define OFF_CHIP_IDENTITY 8'h50
`define OFF_INTERRUPT_CONFIG 8'h54
`define OFF_INTERRUPT_STATUS 8'h58
`define OFF_INTERRUPT_ENABLE 8'h5c
`define OFF_RESERVED_A 8'h60
`define OFF_BYTE_ORDER_PROBE 8'h64
`define OFF_QUEUE_LEVEL_IRQ 8'h68
`define OFF_RECEIVE_CONFIG 8'h6c
`define OFF_TRANSMIT_CONFIG 8'h70
`define OFF_HARDWARE_CONFIG 8'h74
`define OFF_RECEIVE_PATH_CONTROL 8'h78
`define OFF_RECEIVE_QUEUE_INFO 8'h7c
`define OFF_TRANSMIT_QUEUE_INFO 8'h80
`define OFF_POWER_MGMT_CONTROL 8'h84
`define OFF_GENERAL_IO_CONFIG 8'h88
`define OFF_TIMER_CONFIG 8'h8c
`define OFF_TIMER_COUNT 8'h90
`define OFF_RESERVED_B 8'h94
`define OFF_HALFWORD_SWAP 8'h98
`define OFF_FREE_RUNNING_COUNTER 8'h9c
`define OFF_DROPPED_FRAME_COUNTER 8'ha0
`define OFF_MAC_INDIRECT_COMMAND 8'ha4
`define OFF_MAC_INDIRECT_DATA 8'ha8
`define OFF_AUTO_FLOW_CONTROL_CONFIG 8'hac
`define OFF_SERIAL_ROM_COMMAND 8'hb0
`define OFF_SERIAL_ROM_DATA 8'hb4
// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define RST_ZERO 32'h00000000
`define RST_QUEUE_LEVEL_IRQ 32'h48000000
`define RST_HARDWARE_CONFIG 32'h00000800
`define RST_TX_QUEUE_FREE 16'h1200
`define RST_TIMER_CONFIG 32'h0000ffff
`define RST_TIMER_COUNT 32'h0000ffff
`define BYTE_ORDER_VALUE 32'h87654321
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_SOFT_RESET 0
`define FLD_TXQ_LIMIT_HI 19
`define FLD_TXQ_LIMIT_LO 16
`define BIT_TIMER_ENABLE 29
`define BIT_MAC_BUSY 31
`define BIT_MAC_READ 30
`define BIT_SOFT_IRQ 31
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`endif

/* test/host_csr_test.sv */
`timescale 1ns/1ps
`default_nettype none
module host_csr_test;
  import host_csr_pkg::*;
  logic mclk, resetn, host_rd, host_wr, rsp, rdp, tsp, take, drop, slow;
  logic [7:0] host_addr;
  logic [15:0] host_wdata, host_rdata;
  logic host_rvalid, tx_data_avail, tx_data_strobe, mac_req, mac_write;
  logic mac_ack;
  logic [7:0] mac_index;
  logic [31:0] pw, tx_data_out, mac_wdata, mac_rdata;
  logic [40:0] seen;
  logic [2:0] rdy;
  word_t d;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  logic [7:0] ra[7] = '{8'h50, 8'h64, 8'h68, 8'h74, 8'h80, 8'h8c, 8'h90};
  word_t rv[7] = '{32'h3c710002, 32'h87654321, 32'h48000000, 32'h00000800,
    32'h00001200, 32'h0000ffff, 32'h0000ffff};
  logic [7:0] wa[6] = '{8'h50, 8'h64, 8'h60, 8'h94, 8'hb8, 8'hfc};
  host_csr #(.CHIP_CODE(16'h3c71), .CHIP_REV(16'h0002)) host_csr_i (
    .mclk(mclk), .resetn(resetn), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .rx_status_push(rsp), .rx_status_word(pw),
    .rx_status_ready(rdy[0]), .rx_data_push(rdp), .rx_data_word(pw),
    .rx_data_ready(rdy[1]), .tx_status_push(tsp), .tx_status_word(pw),
    .tx_status_ready(rdy[2]), .tx_data_avail(tx_data_avail),
    .tx_data_take(take), .tx_data_out(tx_data_out),
    .tx_data_strobe(tx_data_strobe), .rx_drop_event(drop),
    .mac_req(mac_req), .mac_write(mac_write), .mac_index(mac_index),
    .mac_wdata(mac_wdata), .mac_ack(mac_ack), .mac_rdata(mac_rdata));
  mac_side_model mac_side_model_i (.mclk(mclk), .resetn(resetn),
    .slow(slow), .mac_req(mac_req), .mac_write(mac_write),
    .mac_index(mac_index), .mac_wdata(mac_wdata), .mac_ack(mac_ack),
    .mac_rdata(mac_rdata), .seen_q(seen));
  // ------------------------------------------------------------
  // host bus access, low half first
  // ------------------------------------------------------------
  task automatic rd32(input logic [7:0] a, output word_t r);
    @(posedge mclk) #1;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge mclk) #1;
    host_addr = a | 8'h02;
    r[15:0] = host_rdata;
    @(posedge mclk) #1;
    r[31:16] = host_rdata;
    chk("rvalid", 32'h1, {31'h0, host_rvalid});
    host_rd = 1'b0;
  endtask : rd32
  task automatic wr32(input logic [7:0] a, input word_t w);
    @(posedge mclk) #1;
    host_addr = a;
    host_wdata = w[15:0];
    host_wr = 1'b1;
    @(posedge mclk) #1;
    host_addr = a | 8'h02;
    host_wdata = w[31:16];
    @(posedge mclk) #1;
    host_wr = 1'b0;
  endtask : wr32
  task automatic chk(input string n, input word_t e, input word_t g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input word_t e);
    word_t r;
    rd32(a, r);
    chk($sformatf("read %h", a), e, r);
  endtask : rdchk
  task automatic push(input int k, input word_t w);
    @(posedge mclk) #1;
    pw = w;
    {rsp, rdp, tsp} = 3'b100 >> k;
    @(posedge mclk) #1;
    {rsp, rdp, tsp} = 3'b000;
  endtask : push
  // pop and peek ports of one status queue
  task automatic qtest(input int k, input logic [7:0] a);
    push(k, 32'ha1000000 + k);
    push(k, 32'hb2000000 + k);
    wr32(a, 32'hffffffff);
    rdchk(a + 8'h04, 32'ha1000000 + k);
    rdchk(a, 32'ha1000000 + k);
    rdchk(a + 8'h04, 32'hb2000000 + k);
    rdchk(a, 32'hb2000000 + k);
    rdchk(a, 32'h0);
  endtask : qtest
  task automatic mac_wait;
    for (int i = 0; i < 20 && d[31] !== 1'b0; i++) rd32(8'ha4, d);
    chk("mac busy", 32'h0, {31'h0, d[31]});
  endtask : mac_wait
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // a hang would otherwise never reach the report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    {resetn, host_rd, host_wr, rsp, rdp, tsp, take, drop, slow} = '0;
    host_addr = 8'h0;
    host_wdata = 16'h0;
    pw = 32'h0;
    repeat (20) @(posedge mclk);
    #1 resetn = 1'b1;
    chk("ready", 32'h7, 32'(rdy));
    for (int i = 0; i < 7; i++) rdchk(ra[i], rv[i]);
    // writes keep off reserved offsets; only read-only words are hit
    for (int i = 0; i < 2; i++) wr32(wa[i], 32'hffffffff);
    for (int i = 0; i < 6; i++) rdchk(wa[i], i < 2 ? rv[i] : 32'h0);
    // default split leaves a single receive slot
    push(1, 32'h5a5a0001);
    chk("ready", 32'h5, 32'(rdy));
    rdchk(8'h00, 32'h5a5a0001);
    wr32(8'h74, 32'h00080800);
    rdchk(8'h74, 32'h00080800);
    qtest(0, 8'h40);
    qtest(2, 8'h48);
    push(1, 32'h0c0c0001);
    push(1, 32'h0d0d0002);
    rdchk(8'h00, 32'h0c0c0001);
    rdchk(8'h3c, 32'h0d0d0002);
    rdchk(8'h20, 32'h0);
    wr32(8'h04, 32'h11112222);
    wr32(8'h38, 32'h33334444);
    rdchk(8'h80, 32'h000011f8);
    @(posedge mclk) #1 take = 1'b1;
    @(posedge mclk) #1 take = 1'b0;
    chk("tx word", 32'h11112222, tx_data_out);
    chk("tx strobe", 32'h1, {31'h0, tx_data_strobe});
    chk("tx avail", 32'h1, {31'h0, tx_data_avail});
    @(posedge mclk) #1 drop = 1'b1;
    @(posedge mclk) #1 drop = 1'b0;
    rdchk(8'ha0, 32'h1);
    rdchk(8'ha0, 32'h0);
    wr32(8'ha8, 32'hcafe0001);
    wr32(8'ha4, 32'h80000012);
    d = '1;
    mac_wait();
    chk("mac seen", 32'h112, 32'(seen[40:32]));
    chk("mac wdata", 32'hcafe0001, seen[31:0]);
    slow = 1'b1;
    wr32(8'ha4, 32'hc0000034);
    d = '1;
    mac_wait();
    rdchk(8'ha8, 32'h600d0034);
    wr32(8'h68, 32'h12345678);
    rdchk(8'h68, 32'h12345678);
    wr32(8'h74, 32'h00080801);
    repeat (3) @(posedge mclk);
    rdchk(8'h68, 32'h48000000);
    rdchk(8'h74, 32'h00000800);
    finish_test();
  end
endmodule : host_csr_test
`default_nettype wire

/* test/mac_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// mac side responder for indirect accesses
// ------------------------------------------------------------
module mac_side_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mac_req,
  input wire logic mac_write,
  input wire logic [7:0] mac_index,
  input wire logic [31:0] mac_wdata,
  output logic mac_ack,
  output logic [31:0] mac_rdata,
  output logic [40:0] seen_q
);
  logic [3:0] wait_q;
  // one access at a time; answers after 1 or 6 cycles
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wait_q <= 4'h0;
      seen_q <= '0;
    end else if (mac_req) begin
      wait_q <= slow ? 4'h6 : 4'h1;
      seen_q <= {mac_write, mac_index, mac_wdata};
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
  // data only means something with ack, so it churns otherwise
  assign mac_ack = (wait_q == 4'h1);
  assign mac_rdata = mac_ack ? {24'h600d00, seen_q[39:32]} : {8{~wait_q}};
endmodule : mac_side_model
`default_nettype wire
